// ### hdl/rss_consts.vh
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH
// ************************************************************
// bus addresses
// ************************************************************
`define RSS_CTRL_ADDR 7'h6F
`define RSS_NV_ADDR 7'h57
// ************************************************************
// address map
// ************************************************************
`define RSS_REG_FIRST 8'h00
`define RSS_REG_LAST 8'h1F
`define RSS_SRAM_FIRST 8'h20
`define RSS_SRAM_LAST 8'h5F
`define RSS_NV_FIRST 8'hF0
`define RSS_NV_LAST 8'hF7
`define RSS_DAY_OF_WEEK_FIELD_ADDR 8'h03
`define RSS_DN_MIN_ADDR 8'h18
`define RSS_DN_HOUR_ADDR 8'h19
`define RSS_DN_DATE_ADDR 8'h1A
`define RSS_DN_MTH_ADDR 8'h1B
`define RSS_UP_MIN_ADDR 8'h1C
`define RSS_UP_HOUR_ADDR 8'h1D
`define RSS_UP_DATE_ADDR 8'h1E
`define RSS_UP_MTH_ADDR 8'h1F
// ************************************************************
// field masks and positions
// ************************************************************
`define RSS_MIN_MASK 8'h7F
`define RSS_HOUR_MASK 8'h7F
`define RSS_DATE_MASK 8'h3F
`define RSS_MTH_MASK 8'hFF
`define RSS_DAY_OF_WEEK_FIELD_MASK 8'h3F
`define RSS_OSC_BIT 5
`define RSS_FAIL_BIT 4
`define RSS_VBAT_BIT 3
`define RSS_ZERO8 8'h00
`define RSS_BIT_LAST 3'h7
`endif

// ### hdl/rss_sync.v
`timescale 1ns/100ps
// ************************************************************
// two-stage synchroniser with edge detect on the second stage
// ************************************************************
module rss_sync (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // pin level
  input wire pin_in,
  // synchronised level and edges
  output reg level,
  output wire rise,
  output wire fall
);
  reg meta;
  reg level_d;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= 1'b1;
      level <= 1'b1;
      level_d <= 1'b1;
    end else begin
      meta <= pin_in;
      level <= meta;
      level_d <= level;
    end
  end
  assign rise = level & ~level_d;
  assign fall = ~level & level_d;
endmodule

// ### hdl/rss_target.v
`timescale 1ns/100ps
`include "rss_consts.vh"
module rss_target #(
  parameter SRAM_DEPTH = 64
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // two-wire bus
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // supply state
  input wire on_backup,
  input wire osc_running,
  // clock-calendar time for stamps
  input wire [7:0] time_minutes,
  input wire [7:0] time_hours,
  input wire [7:0] time_date,
  input wire [7:0] time_month,
  // nonvolatile block read data
  input wire [7:0] nv_rdata,
  // register window to the clock-calendar core
  output reg [7:0] core_addr,
  output reg [7:0] core_wdata,
  output reg core_we,
  input wire [7:0] core_rdata,
  // configuration state
  output wire backup_supply_enable,
  output wire power_loss_flag
);
  localparam ST_IDLE = 3'd0, ST_ADDR = 3'd1, ST_WORD = 3'd2, ST_DATA = 3'd3;
  localparam ST_READ = 3'd4, ST_RACK = 3'd5, ST_ACK = 3'd6;

  // ************************************************************
  // helper functions
  // ************************************************************
  function [7:0] next_ptr;
    input [7:0] a;
    begin
      if (a == `RSS_REG_LAST)
        next_ptr = `RSS_REG_FIRST;
      else if (a == `RSS_SRAM_LAST)
        next_ptr = `RSS_SRAM_FIRST;
      else if (a == `RSS_NV_LAST)
        next_ptr = `RSS_NV_FIRST;
      else
        next_ptr = a + 8'h01;
    end
  endfunction

  function in_sram;
    input [7:0] a;
    begin
      in_sram = (a >= `RSS_SRAM_FIRST) && (a <= `RSS_SRAM_LAST);
    end
  endfunction

  // ************************************************************
  // pin sampling
  // ************************************************************
  wire scl, scl_rise, scl_fall;
  wire sda, sda_rise, sda_fall;
  rss_sync u_scl (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(scl_in),
    .level(scl),
    .rise(scl_rise),
    .fall(scl_fall)
  );
  rss_sync u_sda (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(sda_in),
    .level(sda),
    .rise(sda_rise),
    .fall(sda_fall)
  );
  wire start_det = sda_fall & scl;
  wire stop_det = sda_rise & scl;

  // ************************************************************
  // storage
  // ************************************************************
  reg [7:0] sram [0:SRAM_DEPTH-1];
  reg [7:0] dn_min, dn_hour, dn_date, dn_mth;
  reg [7:0] up_min, up_hour, up_date, up_mth;
  reg [7:0] day_of_week_field;
  reg backup_d;

  // ************************************************************
  // protocol state
  // ************************************************************
  reg [2:0] state, after_ack, bit_cnt;
  reg [7:0] shift, ptr;
  reg nv_sel, drive_low, ack_pending, wr_pending;

  wire [7:0] dev_byte = {shift[6:0], sda};
  wire sram_hit = in_sram(ptr);
  wire [7:0] sram_off = ptr - `RSS_SRAM_FIRST;
  wire [5:0] sram_idx = sram_off[5:0];

  // read mux, unimplemented bits masked to zero
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = `RSS_ZERO8;
    if (nv_sel)
      rd_byte = nv_rdata;
    else if (sram_hit)
      rd_byte = sram[sram_idx];
    else begin
      case (ptr)
        `RSS_DAY_OF_WEEK_FIELD_ADDR: rd_byte = day_of_week_field & `RSS_DAY_OF_WEEK_FIELD_MASK;
        `RSS_DN_MIN_ADDR: rd_byte = dn_min & `RSS_MIN_MASK;
        `RSS_DN_HOUR_ADDR: rd_byte = dn_hour & `RSS_HOUR_MASK;
        `RSS_DN_DATE_ADDR: rd_byte = dn_date & `RSS_DATE_MASK;
        `RSS_DN_MTH_ADDR: rd_byte = dn_mth;
        `RSS_UP_MIN_ADDR: rd_byte = up_min & `RSS_MIN_MASK;
        `RSS_UP_HOUR_ADDR: rd_byte = up_hour & `RSS_HOUR_MASK;
        `RSS_UP_DATE_ADDR: rd_byte = up_date & `RSS_DATE_MASK;
        `RSS_UP_MTH_ADDR: rd_byte = up_mth;
        default: rd_byte = core_rdata;
      endcase
    end
  end

  wire wk_write = wr_pending && !nv_sel && (ptr == `RSS_DAY_OF_WEEK_FIELD_ADDR);
  wire fail_clear = wk_write && !core_wdata[`RSS_FAIL_BIT];

  // ************************************************************
  // bus state machine
  // ************************************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      bit_cnt <= 3'd0;
      shift <= `RSS_ZERO8;
      ptr <= `RSS_REG_FIRST;
      nv_sel <= 1'b0;
      drive_low <= 1'b0;
      ack_pending <= 1'b0;
      wr_pending <= 1'b0;
      core_addr <= `RSS_ZERO8;
      core_wdata <= `RSS_ZERO8;
      core_we <= 1'b0;
    end else begin
      core_we <= 1'b0;
      wr_pending <= 1'b0;
      if (wr_pending) begin
        ptr <= next_ptr(ptr);
      end
      if (start_det) begin
        state <= ST_ADDR;
        bit_cnt <= 3'd0;
        drive_low <= 1'b0;
        ack_pending <= 1'b0;
      end else if (stop_det) begin
        state <= ST_IDLE;
        drive_low <= 1'b0;
        ack_pending <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            drive_low <= 1'b0;
          end
          ST_ADDR, ST_WORD, ST_DATA: begin
            if (scl_rise) begin
              shift <= dev_byte;
              bit_cnt <= bit_cnt + 3'd1;
              if (bit_cnt == `RSS_BIT_LAST) begin
                ack_pending <= 1'b1;
                if (state == ST_ADDR) begin
                  if (dev_byte[7:1] == `RSS_CTRL_ADDR && !on_backup) begin
                    nv_sel <= 1'b0;
                    after_ack <= dev_byte[0] ? ST_READ : ST_WORD;
                  end else if (dev_byte[7:1] == `RSS_NV_ADDR && !on_backup) begin
                    nv_sel <= 1'b1;
                    after_ack <= dev_byte[0] ? ST_READ : ST_WORD;
                  end else begin
                    ack_pending <= 1'b0;
                    state <= ST_IDLE;
                  end
                end else if (state == ST_WORD) begin
                  if (!nv_sel && dev_byte > `RSS_SRAM_LAST) begin
                    ack_pending <= 1'b0;
                    state <= ST_IDLE;
                  end else begin
                    ptr <= dev_byte;
                    after_ack <= ST_DATA;
                  end
                end else begin
                  if (nv_sel) begin
                    after_ack <= ST_DATA;
                  end else begin
                    core_addr <= ptr;
                    core_wdata <= dev_byte;
                    core_we <= !sram_hit;
                    wr_pending <= 1'b1;
                    after_ack <= ST_DATA;
                  end
                end
              end
            end else if (scl_fall && ack_pending) begin
              drive_low <= 1'b1;
              ack_pending <= 1'b0;
              state <= ST_ACK;
              bit_cnt <= 3'd0;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              drive_low <= 1'b0;
              state <= after_ack;
              if (after_ack == ST_READ) begin
                shift <= rd_byte;
                drive_low <= ~rd_byte[7];
                bit_cnt <= 3'd0;
              end
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'd1;
              if (bit_cnt == `RSS_BIT_LAST) begin
                drive_low <= 1'b0;
                ptr <= next_ptr(ptr);
                state <= ST_RACK;
              end else begin
                shift <= {shift[6:0], 1'b0};
                drive_low <= ~shift[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda)
                state <= ST_IDLE;
              else
                after_ack <= ST_READ;
            end else if (scl_fall && after_ack == ST_READ) begin
              shift <= rd_byte;
              drive_low <= ~rd_byte[7];
              bit_cnt <= 3'd0;
              state <= ST_READ;
              after_ack <= ST_IDLE;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // sram write port, no reset so contents survive
  // ************************************************************
  always @(posedge clk) begin
    if (wr_pending && !nv_sel && sram_hit)
      sram[sram_idx] <= core_wdata;
  end

  // ************************************************************
  // stamps, weekday register and power-fail logging
  // ************************************************************
  wire to_backup = on_backup & ~backup_d;
  wire from_backup = ~on_backup & backup_d;
  wire log_ok = ~day_of_week_field[`RSS_FAIL_BIT] & day_of_week_field[`RSS_VBAT_BIT];
  wire st_write = wr_pending && !nv_sel;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      backup_d <= 1'b0;
      day_of_week_field <= `RSS_ZERO8;
      dn_min <= `RSS_ZERO8;
      dn_hour <= `RSS_ZERO8;
      dn_date <= `RSS_ZERO8;
      dn_mth <= `RSS_ZERO8;
      up_min <= `RSS_ZERO8;
      up_hour <= `RSS_ZERO8;
      up_date <= `RSS_ZERO8;
      up_mth <= `RSS_ZERO8;
    end else begin
      backup_d <= on_backup;
      day_of_week_field[`RSS_OSC_BIT] <= osc_running;
      if (wk_write)
        day_of_week_field[3:0] <= core_wdata[3:0];
      if (fail_clear && !(to_backup && log_ok) && !(from_backup && day_of_week_field[`RSS_VBAT_BIT]))
        day_of_week_field[`RSS_FAIL_BIT] <= 1'b0;
      if (st_write) begin
        case (ptr)
          `RSS_DN_MIN_ADDR: dn_min <= core_wdata & `RSS_MIN_MASK;
          `RSS_DN_HOUR_ADDR: dn_hour <= core_wdata & `RSS_HOUR_MASK;
          `RSS_DN_DATE_ADDR: dn_date <= core_wdata & `RSS_DATE_MASK;
          `RSS_DN_MTH_ADDR: dn_mth <= core_wdata & `RSS_MTH_MASK;
          `RSS_UP_MIN_ADDR: up_min <= core_wdata & `RSS_MIN_MASK;
          `RSS_UP_HOUR_ADDR: up_hour <= core_wdata & `RSS_HOUR_MASK;
          `RSS_UP_DATE_ADDR: up_date <= core_wdata & `RSS_DATE_MASK;
          `RSS_UP_MTH_ADDR: up_mth <= core_wdata & `RSS_MTH_MASK;
          default: ;
        endcase
      end
      if (fail_clear) begin
        dn_min <= `RSS_ZERO8;
        dn_hour <= `RSS_ZERO8;
        dn_date <= `RSS_ZERO8;
        dn_mth <= `RSS_ZERO8;
        up_min <= `RSS_ZERO8;
        up_hour <= `RSS_ZERO8;
        up_date <= `RSS_ZERO8;
        up_mth <= `RSS_ZERO8;
      end
      if (to_backup && log_ok) begin
        dn_min <= time_minutes & `RSS_MIN_MASK;
        dn_hour <= time_hours & `RSS_HOUR_MASK;
        dn_date <= time_date & `RSS_DATE_MASK;
        dn_mth <= time_month;
        day_of_week_field[`RSS_FAIL_BIT] <= 1'b1;
      end
      if (from_backup && day_of_week_field[`RSS_VBAT_BIT]) begin
        up_min <= time_minutes & `RSS_MIN_MASK;
        up_hour <= time_hours & `RSS_HOUR_MASK;
        up_date <= time_date & `RSS_DATE_MASK;
        up_mth <= time_month;
        day_of_week_field[`RSS_FAIL_BIT] <= 1'b1;
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign sda_out = 1'b0;
  assign sda_oe = drive_low;
  assign backup_supply_enable = day_of_week_field[`RSS_VBAT_BIT];
  assign power_loss_flag = day_of_week_field[`RSS_FAIL_BIT];
endmodule

// ### verif/rss_assertions.sv
`timescale 1ns/100ps
// ************************************************************
// bus and supply checks
// ************************************************************
module rss_checker (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // pins and supply
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire on_backup,
  // core window and flags
  input wire [7:0] core_addr,
  input wire [7:0] core_wdata,
  input wire core_we,
  input wire backup_supply_enable,
  input wire power_loss_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_od_low; sda_out == 1'b0; endproperty
  a_od_low: assert property (p_od_low) else $error("sda_out high");
  property p_we_pulse; core_we |=> !core_we; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write pulse too long");
  property p_we_regs; core_we |-> core_addr <= 8'h1F; endproperty
  a_we_regs: assert property (p_we_regs) else $error("core write outside registers");
  property p_backup_no_we; on_backup [*8] |-> !core_we; endproperty
  a_backup_no_we: assert property (p_backup_no_we) else $error("write on backup");
  property p_backup_no_ack; on_backup [*8] |-> !sda_oe; endproperty
  a_backup_no_ack: assert property (p_backup_no_ack) else $error("ack on backup");
  // drive changes belong to the low phase of the bus clock
  property p_oe_scl_low;
    $changed(sda_oe) |-> !(scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3));
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
  property p_flag_set;
    $rose(on_backup) && backup_supply_enable && !power_loss_flag |-> ##[1:4] power_loss_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("loss flag not set");
  property p_enable_wr;
    core_we && core_addr == 8'h03 |-> ##[0:3] backup_supply_enable == core_wdata[3];
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("enable bit not stored");
  c_write: cover property (core_we);
  c_fail: cover property ($rose(power_loss_flag));
  c_ack: cover property ($rose(sda_oe));
endmodule
bind rss_target rss_checker u_chk (
  .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .on_backup(on_backup), .core_addr(core_addr), .core_wdata(core_wdata), .core_we(core_we),
  .backup_supply_enable(backup_supply_enable), .power_loss_flag(power_loss_flag)
);

// ### verif/rss_master.sv
`timescale 1ns/100ps
// ************************************************************
// bit-level two-wire bus master, clock idles high
// ************************************************************
module rss_master (
  // clock
  input wire clk,
  // bus
  input wire sda,
  output reg scl,
  output reg sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task quarter;
    begin
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  // also a repeated start from clock low
  task bus_start;
    begin
      sda_low = 1'b0;
      quarter;
      scl = 1'b1;
      quarter;
      sda_low = 1'b1;
      quarter;
      scl = 1'b0;
      quarter;
    end
  endtask
  task bus_stop;
    begin
      sda_low = 1'b1;
      quarter;
      scl = 1'b1;
      quarter;
      sda_low = 1'b0;
      quarter;
      quarter;
    end
  endtask
  task bit_io(input b, output r);
    begin
      sda_low = !b;
      quarter;
      scl = 1'b1;
      quarter;
      r = sda;
      quarter;
      scl = 1'b0;
      quarter;
    end
  endtask
  task wbyte(input [7:0] d, output ack);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
    end
  endtask
  // last byte left unacknowledged
  task rbyte(input last, output [7:0] d);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(1'b1, r);
        d[i] = r;
      end
      bit_io(last, r);
    end
  endtask
endmodule

// ### verif/tb_rtc_sram_serial_access.sv
`timescale 1ns/100ps
`include "rss_consts.vh"
module tb_rtc_sram_serial_access;
  reg clk, reset_n, on_backup, ok_c, ok_a, ok_d;
  reg [7:0] time_minutes, time_hours, time_date, time_month, last_ca, last_cd;
  reg [7:0] rb [0:7];
  reg [7:0] wd [0:7];
  wire scl, sda_low, sda_out, sda_oe, core_we, bse, plf;
  wire [7:0] core_addr, core_wdata;
  wire sda = !sda_low && !(sda_oe && !sda_out);
  integer fail_count, total_checks, i;
  rss_target DUT (
    .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .on_backup(on_backup), .osc_running(1'b1),
    .time_minutes(time_minutes), .time_hours(time_hours), .time_date(time_date),
    .time_month(time_month), .nv_rdata(8'hC3), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_we(core_we), .core_rdata(8'h5A),
    .backup_supply_enable(bse), .power_loss_flag(plf)
  );
  rss_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (core_we) begin
    last_ca <= core_addr;
    last_cd <= core_wdata;
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task chk1(input b, input e);
    chk({7'h00, b}, {7'h00, e});
  endtask
  task send(input [6:0] dev, input [7:0] a, input integer n);
    reg k;
    begin
      m.bus_start;
      m.wbyte({dev, 1'b0}, ok_c);
      m.wbyte(a, ok_a);
      ok_d = 1'b1;
      for (i = 0; i < n; i = i + 1) begin
        m.wbyte(wd[i], k);
        ok_d = ok_d & k;
      end
      m.bus_stop;
    end
  endtask
  task rd(input [6:0] dev, input [7:0] a, input integer n, input cur);
    begin
      m.bus_start;
      if (!cur) begin
        m.wbyte({dev, 1'b0}, ok_c);
        m.wbyte(a, ok_a);
        m.bus_start;
      end
      m.wbyte({dev, 1'b1}, ok_c);
      for (i = 0; i < n; i = i + 1) begin
        m.rbyte(i == n - 1, rb[i]);
      end
      m.bus_stop;
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  initial begin
    #2000000;
    fail_count = fail_count + 1;
    tally_and_finish;
  end
  initial begin
    fail_count = 0;
    total_checks = 0;
    reset_n = 1'b0;
    on_backup = 1'b0;
    {time_minutes, time_hours, time_date, time_month} = 32'h00000000;
    repeat (12) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rd(`RSS_CTRL_ADDR, `RSS_DN_MTH_ADDR, 5, 1'b0);
    for (i = 0; i < 5; i = i + 1) begin
      chk(rb[i], 8'h00);
    end
    $display("test reset values done");
    wd[0] = 8'hA1;
    wd[1] = 8'hA2;
    wd[2] = 8'hA3;
    send(`RSS_CTRL_ADDR, 8'h5E, 3);
    chk1(ok_d, 1'b1);
    rd(`RSS_CTRL_ADDR, 8'h5F, 1, 1'b0);
    chk(rb[0], 8'hA2);
    rd(`RSS_CTRL_ADDR, 8'h00, 1, 1'b1);
    chk(rb[0], 8'hA3);
    rd(`RSS_CTRL_ADDR, 8'h5E, 3, 1'b0);
    for (i = 0; i < 3; i = i + 1) begin
      chk(rb[i], wd[i]);
    end
    $display("test sram wrap done");
    send(`RSS_CTRL_ADDR, 8'h60, 1);
    chk1(ok_c, 1'b1);
    chk1(ok_a, 1'b0);
    chk1(ok_d, 1'b0);
    m.bus_start;
    m.wbyte(8'hD0, ok_c);
    m.bus_stop;
    chk1(ok_c, 1'b0);
    rd(`RSS_NV_ADDR, 8'hF0, 1, 1'b0);
    chk1(ok_c, 1'b1);
    chk(rb[0], 8'hC3);
    $display("test refusals done");
    wd[0] = 8'hF9;
    wd[1] = 8'h34;
    send(`RSS_CTRL_ADDR, `RSS_UP_MTH_ADDR, 2);
    chk(last_ca, 8'h00);
    chk(last_cd, 8'h34);
    rd(`RSS_CTRL_ADDR, 8'h00, 1, 1'b1);
    chk(rb[0], 8'h5A);
    rd(`RSS_CTRL_ADDR, `RSS_UP_MTH_ADDR, 1, 1'b0);
    chk(rb[0], 8'hF9);
    $display("test register wrap done");
    wd[0] = 8'h08;
    send(`RSS_CTRL_ADDR, `RSS_DAY_OF_WEEK_FIELD_ADDR, 1);
    chk1(bse, 1'b1);
    time_month = 8'h12;
    on_backup = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk1(plf, 1'b1);
    send(`RSS_CTRL_ADDR, 8'h5E, 1);
    chk1(ok_c, 1'b0);
    on_backup = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rd(`RSS_CTRL_ADDR, `RSS_DN_MTH_ADDR, 1, 1'b0);
    chk(rb[0], 8'h12);
    rd(`RSS_CTRL_ADDR, `RSS_DAY_OF_WEEK_FIELD_ADDR, 1, 1'b0);
    chk(rb[0], 8'h38);
    send(`RSS_CTRL_ADDR, `RSS_DAY_OF_WEEK_FIELD_ADDR, 1);
    chk1(plf, 1'b0);
    rd(`RSS_CTRL_ADDR, `RSS_UP_MTH_ADDR, 1, 1'b0);
    chk(rb[0], 8'h00);
    $display("test supply stamps done");
    tally_and_finish;
  end
endmodule
